// *** core/dtoc_defs.vh ***
// Purpose: constants for the diagnostic test-option control block
// Assumes: one 200 MHz clock, synchronous active-low reset
// Notes: definitions only
`ifndef DTOC_DEFS_VH
`define DTOC_DEFS_VH
`define DTOC_PARAM_FIRST      8'h80
`define DTOC_PARAM_LAST       8'h8F
`define DTOC_TEST_OPTION_ADDR 8'h80
`define DTOC_TEST_OPTION_RST  16'h0000
`define DTOC_OPT_STOP_AT_END  0
`define DTOC_OPT_SINGLE_STEP  1
`define DTOC_OPT_LOG_ERROR    2
`define DTOC_OPT_ERR_OVERRIDE 3
`define DTOC_OPT_USED_MASK    16'h00FF
`define DTOC_SEEK_LIMIT       16'd10000
`define DTOC_FAULT_LOG_FIRST  8'hB0
`define DTOC_FAULT_LOG_LAST   8'hCF
`define DTOC_ERROR_LOG_FIRST  8'hD0
`define DTOC_ERROR_LOG_LAST   8'hEF
`define DTOC_DIAG_EXC_A       8'h02
`define DTOC_DIAG_EXC_B       8'h05
`define DTOC_SEEK_DIRECT      3'h0
`define DTOC_SEEK_RANDOM      3'h1
`define DTOC_SEEK_SEQ_FWD     3'h2
`define DTOC_SEEK_SEQ_REV     3'h3
`define DTOC_SEEK_SEQ_FWDREV  3'h4
`define DTOC_SEEK_CROSS       3'h5
`endif

// *** core/dtoc_log_mem.v ***
// Purpose: 32-entry log memory, registered read
// Assumes: single clock
// Notes: no reset on storage
`timescale 1ns/10ps
module dtoc_log_mem (
  input  wire       clk_i,
  input  wire       we_i,
  input  wire [4:0] waddr_i,
  input  wire [7:0] wdata_i,
  input  wire [4:0] raddr_i,
  output reg  [7:0] rdata_o
);
  reg [7:0] mem [0:31];
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule // dtoc_log_mem

// *** core/dtoc_panel_entry.v ***
// Purpose: assembles panel digit-pair entries into parameter writes
// Assumes: strobes already synchronised and single-cycle
// Notes: a value entry is two digit pairs, high pair first
`timescale 1ns/10ps
`include "dtoc_defs.vh"
module dtoc_panel_entry (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        entry_stb_i,
  input  wire        select_i,
  input  wire [7:0]  digits_i,
  output reg  [7:0]  param_sel_o,
  output reg         param_wr_o,
  output reg  [15:0] param_val_o,
  output reg         sel_valid_o
);
  reg       half;
  reg [7:0] high_pair;
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      param_sel_o <= 8'h00;
      param_wr_o  <= 1'b0;
      param_val_o <= 16'h0000;
      sel_valid_o <= 1'b0;
      half        <= 1'b0;
      high_pair   <= 8'h00;
    end else begin
      param_wr_o <= 1'b0;
      if (entry_stb_i && select_i) begin
        // RULE1: selector range check
        sel_valid_o <= (digits_i >= `DTOC_PARAM_FIRST) && (digits_i <= `DTOC_PARAM_LAST);
        param_sel_o <= digits_i;
        half        <= 1'b0;
      end else if (entry_stb_i && sel_valid_o) begin
        // RULE2: two pairs form value
        if (!half) begin
          high_pair <= digits_i;
          half      <= 1'b1;
        end else begin
          param_val_o <= {high_pair, digits_i};
          param_wr_o  <= 1'b1;
          half        <= 1'b0;
        end
      end
    end
  end
endmodule // dtoc_panel_entry

// *** core/dtoc_test_control.v ***
// Purpose: test-option parameter and run/stop control of seek and diagnostic tests
// Assumes: panel switches asynchronous; seek and test engines on clk_i
// Notes: Notes on behaviour
// Notes on behaviour
// RULE1: A selector 80..8F must be entered before any value is accepted.
// RULE2: A value is four digits taken as two successive digit pairs.
// RULE3: Only the first two digits of the test option carry bits; the last two are dropped.
// RULE4: Field direct or random seeks with stop-at-end stop after 10000 seeks.
// RULE5: Field sequential seeks with stop-at-end stop after one pass.
// RULE6: Field cross-pattern seeks with stop-at-end stop after all combinations.
// RULE7: The operator should not use stop-at-end for read, write or direct seek; nothing enforces it.
// RULE8: After an end stop, restart needs clear, then reload, then initiate.
// RULE9: Field seeks without stop-at-end repeat until initiate is pressed again.
// RULE10: Diagnostic tests with stop-at-end run once and stop.
// RULE11: Diagnostic tests without stop-at-end loop until initiate, except tests 02 and 05.
// RULE12: With single-step set, one access is made per initiate.
// RULE13: With log-error set, function faults are counted and logged at B0..CF.
// RULE14: Function faults are always logged uncounted at D0..EF.
// RULE15: An entered value holds until re-entered or reset; unused bits read zero.
`timescale 1ns/10ps
`include "dtoc_defs.vh"
module dtoc_test_control (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        entry_stb_i,
  input  wire        select_i,
  input  wire [7:0]  digits_i,
  input  wire        initiate_i,
  input  wire        clear_i,
  input  wire        reload_i,
  input  wire        field_seek_run_mode_i,
  input  wire [2:0]  seek_kind_i,
  input  wire [7:0]  diag_test_i,
  input  wire        access_done_i,
  input  wire        pass_done_i,
  input  wire        all_combos_done_i,
  input  wire        test_done_i,
  input  wire        fault_i,
  input  wire [7:0]  function_fault_code_i,
  input  wire [7:0]  log_raddr_i,
  output wire [15:0] test_option_parameter_o,
  output wire        stop_at_end_option_o,
  output reg         running_o,
  output reg         end_stop_o,
  output reg         access_req_o,
  output reg  [15:0] seek_count_o,
  output reg  [7:0]  fault_count_o,
  output wire [7:0]  log_rdata_o
);
  localparam ST_IDLE   = 2'd0;
  localparam ST_RUN    = 2'd1;
  localparam ST_ENDED  = 2'd2;
  localparam ST_CLEARD = 2'd3;

  // Two-flop synchronisers for the entry strobe and panel switch pins
  reg [3:0] sync1;
  reg [3:0] sync2;
  reg [3:0] sync_prev;
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1     <= 4'h0;
      sync2     <= 4'h0;
      sync_prev <= 4'h0;
    end else begin
      sync1     <= {entry_stb_i, initiate_i, clear_i, reload_i};
      sync2     <= sync1;
      sync_prev <= sync2;
    end
  end
  wire [3:0] rise       = sync2 & ~sync_prev;
  wire       entry_p    = rise[3];
  wire       initiate_p = rise[2];
  wire       clear_p    = rise[1];
  wire       reload_p   = rise[0];

  // Digits and selector are stable long before the strobe edge is seen
  wire [7:0]  param_sel;
  wire        param_wr;
  wire [15:0] param_val;
  dtoc_panel_entry u_entry (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .entry_stb_i (entry_p),
    .select_i    (select_i),
    .digits_i    (digits_i),
    .param_sel_o (param_sel),
    .param_wr_o  (param_wr),
    .param_val_o (param_val),
    .sel_valid_o ()
  );

  // Only the low byte of the reset word is ever held
  wire [15:0] opt_rst = `DTOC_TEST_OPTION_RST;
  reg  [7:0]  opt_bits;
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      opt_bits <= opt_rst[7:0];
    // RULE15: hold until re-entry
    end else if (param_wr && (param_sel == `DTOC_TEST_OPTION_ADDR)) begin
      // RULE3: keep first digit pair
      opt_bits <= param_val[15:8];
    end
  end
  assign test_option_parameter_o = {8'h00, opt_bits} & `DTOC_OPT_USED_MASK;
  wire stop_at_end = opt_bits[`DTOC_OPT_STOP_AT_END];
  wire single_step = opt_bits[`DTOC_OPT_SINGLE_STEP];
  wire log_error   = opt_bits[`DTOC_OPT_LOG_ERROR];
  assign stop_at_end_option_o = stop_at_end;

  wire seek_counted = (seek_kind_i == `DTOC_SEEK_DIRECT) || (seek_kind_i == `DTOC_SEEK_RANDOM);
  wire seek_seq     = (seek_kind_i == `DTOC_SEEK_SEQ_FWD) || (seek_kind_i == `DTOC_SEEK_SEQ_REV) ||
                      (seek_kind_i == `DTOC_SEEK_SEQ_FWDREV);
  wire diag_except  = (diag_test_i == `DTOC_DIAG_EXC_A) || (diag_test_i == `DTOC_DIAG_EXC_B);
  wire next_count_hit = (seek_count_o + 16'd1) >= `DTOC_SEEK_LIMIT;

  reg end_cond;
  always @* begin
    end_cond = 1'b0;
    if (field_seek_run_mode_i) begin
      if (stop_at_end) begin
        // RULE4: stop after 10000 seeks
        if (seek_counted) begin
          end_cond = access_done_i && next_count_hit;
        // RULE5: stop after one pass
        end else if (seek_seq) begin
          end_cond = pass_done_i;
        // RULE6: stop after all combinations
        end else if (seek_kind_i == `DTOC_SEEK_CROSS) begin
          end_cond = all_combos_done_i;
        end
      end
    end else begin
      // RULE10: run once
      // RULE11: exceptions end themselves
      end_cond = test_done_i && (stop_at_end || diag_except);
    end
  end

  reg [1:0] state;
  reg       step_pending;
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      state        <= ST_IDLE;
      running_o    <= 1'b0;
      end_stop_o   <= 1'b0;
      access_req_o <= 1'b0;
      seek_count_o <= 16'h0000;
      step_pending <= 1'b0;
    end else begin
      access_req_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (initiate_p) begin
            state        <= ST_RUN;
            running_o    <= 1'b1;
            seek_count_o <= 16'h0000;
            step_pending <= 1'b1;
          end
        end
        ST_RUN: begin
          // RULE12: one access per initiate
          if (single_step) begin
            if (step_pending) begin
              access_req_o <= 1'b1;
              step_pending <= 1'b0;
            end else if (initiate_p) begin
              step_pending <= 1'b1;
            end
          end else begin
            access_req_o <= 1'b1;
          end
          if (access_done_i) begin
            seek_count_o <= seek_count_o + 16'd1;
          end
          if (end_cond) begin
            state      <= ST_ENDED;
            running_o  <= 1'b0;
            end_stop_o <= 1'b1;
          // RULE9: initiate stops loop
          end else if (initiate_p && !single_step) begin
            state     <= ST_IDLE;
            running_o <= 1'b0;
          end
        end
        ST_ENDED: begin
          // RULE8: clear first
          if (clear_p) begin
            state      <= ST_CLEARD;
            end_stop_o <= 1'b0;
          end
        end
        ST_CLEARD: begin
          // RULE8: reload then initiate
          if (reload_p) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Fault logging: error area always, fault area only when counting
  reg [4:0] err_ptr;
  reg [4:0] flt_ptr;
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      err_ptr       <= 5'h00;
      flt_ptr       <= 5'h00;
      fault_count_o <= 8'h00;
    end else if (fault_i) begin
      // RULE14: always logged
      err_ptr <= err_ptr + 5'd1;
      // RULE13: counted when enabled
      if (log_error) begin
        flt_ptr       <= flt_ptr + 5'd1;
        fault_count_o <= fault_count_o + 8'd1;
      end
    end
  end

  wire       rd_err = log_raddr_i >= `DTOC_ERROR_LOG_FIRST;
  wire [7:0] rd_off = log_raddr_i - (rd_err ? `DTOC_ERROR_LOG_FIRST : `DTOC_FAULT_LOG_FIRST);
  wire [7:0] err_rdata;
  wire [7:0] flt_rdata;
  reg        rd_err_q;
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_err_q <= 1'b0;
    end else begin
      rd_err_q <= rd_err;
    end
  end
  assign log_rdata_o = rd_err_q ? err_rdata : flt_rdata;

  dtoc_log_mem u_err_log (
    .clk_i   (clk_i),
    .we_i    (fault_i),
    .waddr_i (err_ptr),
    .wdata_i (function_fault_code_i),
    .raddr_i (rd_off[4:0]),
    .rdata_o (err_rdata)
  );

  dtoc_log_mem u_flt_log (
    .clk_i   (clk_i),
    .we_i    (fault_i && log_error),
    .waddr_i (flt_ptr),
    .wdata_i (function_fault_code_i),
    .raddr_i (rd_off[4:0]),
    .rdata_o (flt_rdata)
  );
endmodule // dtoc_test_control

// *** tb/dtoc_chk_sva.sv ***
// Purpose: port checks for the test-option control block
// Assumes: bound to dtoc_test_control, one clock
// Notes: an end stop may show one or two cycles after its cause
`timescale 1ns/10ps
module dtoc_chk (
  input logic        clk_i,
  input logic        rst_n_i,
  input logic        entry_stb_i,
  input logic        field_seek_run_mode_i,
  input logic [2:0]  seek_kind_i,
  input logic        access_done_i,
  input logic        pass_done_i,
  input logic        all_combos_done_i,
  input logic        test_done_i,
  input logic        fault_i,
  input logic [15:0] test_option_parameter_o,
  input logic        running_o,
  input logic        end_stop_o,
  input logic        access_req_o,
  input logic [15:0] seek_count_o,
  input logic [7:0]  fault_count_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [3:0] quiet;
  wire stop_at_end_option = test_option_parameter_o[0];
  wire field_seek_run_mode = running_o && field_seek_run_mode_i && stop_at_end_option;
  // Entry takes about four cycles through the synchroniser
  always @(posedge clk_i) begin
    if (!rst_n_i || entry_stb_i) quiet <= 4'h0;
    else if (quiet != 4'hF) quiet <= quiet + 4'h1;
  end
  chk_upper_zero: assert property (test_option_parameter_o[15:8] == 8'h00)
    else $error("option upper byte set");
  chk_option_hold: assert property (!$stable(test_option_parameter_o) |-> quiet < 4'h9)
    else $error("option changed without entry");
  chk_seek_limit: assert property (
    field_seek_run_mode && seek_kind_i < 3'h2 && access_done_i && seek_count_o == 16'd9999 |-> ##[1:2] end_stop_o)
    else $error("no stop at seek limit");
  chk_one_pass: assert property (
    field_seek_run_mode && seek_kind_i inside {3'h2, 3'h3, 3'h4} && pass_done_i |-> ##[1:2] end_stop_o)
    else $error("no stop after pass");
  chk_all_combos: assert property (field_seek_run_mode && seek_kind_i == 3'h5 && all_combos_done_i |-> ##[1:2] end_stop_o)
    else $error("no stop after combinations");
  chk_diag_once: assert property (
    running_o && !field_seek_run_mode_i && stop_at_end_option && test_done_i |-> ##[1:2] end_stop_o)
    else $error("diagnostic test did not stop");
  chk_seek_repeat: assert property (running_o && field_seek_run_mode_i && !stop_at_end_option |=> !$rose(end_stop_o))
    else $error("seek run stopped by itself");
  chk_restart_clear: assert property ($rose(running_o) |-> !end_stop_o)
    else $error("restart without clear");
  chk_single_step: assert property (access_req_o && test_option_parameter_o[1] |=> !access_req_o)
    else $error("extra access in single step");
  chk_fault_count: assert property (
    fault_i |=> fault_count_o == $past(fault_count_o) + {7'h00, $past(test_option_parameter_o[2])})
    else $error("fault count wrong");
endmodule // dtoc_chk

// *** tb/dtoc_panel_op.sv ***
// Purpose: operator at the diagnostic panel
// Assumes: a switch is held 4 cycles, no bounce
// Notes: digit lines show inverted data three cycles after the strobe is released
`timescale 1ns/10ps
module dtoc_panel_op (
  input  wire        clk_i,
  output logic       entry_stb_o,
  output logic       select_o,
  output logic [7:0] digits_o,
  output logic [2:0] sw_o
);
  initial begin
    {entry_stb_o, select_o, sw_o} = 5'h00;
    digits_o = 8'hFF;
  end
  task automatic edges(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // stop-at-end use left to the bench
  task automatic press(input int w);
    edges(1);
    sw_o = 3'h1 << w;
    edges(4);
    sw_o = 3'h0;
    edges(4);
  endtask
  task automatic enter(input logic s, input logic [7:0] d);
    edges(1);
    select_o = s;
    digits_o = d;
    entry_stb_o = 1'b1;
    edges(4);
    entry_stb_o = 1'b0;
    edges(3);
    digits_o = ~d;
    edges(2);
  endtask
endmodule // dtoc_panel_op

// *** tb/tb_top.sv ***
// Purpose: self-checking bench for the test-option control block
// Assumes: engines modelled as one-cycle pulses
// Notes: two 10000-seek runs take most of the time
`timescale 1ns/10ps
`define CHK(n, e, a) begin \
  total_checks++; \
  if ((a) !== (e)) begin \
    err_count++; \
    $display("Error %s expected %h seen %h", n, e, a); \
  end \
end
module tb_top;
  logic       clk_i;
  logic       rst_n_i;
  logic       mode;
  logic [2:0] kind;
  logic [7:0] test;
  logic [7:0] code;
  logic [7:0] raddr;
  logic [4:0] ev;
  wire        stb, sel, eot_o, run, ends, req;
  wire [2:0]  sw;
  wire [7:0]  dig, rdata, fcnt;
  wire [15:0] opt, scnt;
  int         err_count = 0;
  int         total_checks = 0;
  int         nreq = 0;
  int         m;
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (req === 1'b1) nreq++;
  dtoc_panel_op i_op (.clk_i(clk_i), .entry_stb_o(stb), .select_o(sel), .digits_o(dig), .sw_o(sw));
  dtoc_test_control i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .entry_stb_i(stb), .select_i(sel),
    .digits_i(dig), .initiate_i(sw[0]), .clear_i(sw[1]), .reload_i(sw[2]), .field_seek_run_mode_i(mode),
    .seek_kind_i(kind), .diag_test_i(test), .access_done_i(ev[0]), .pass_done_i(ev[1]),
    .all_combos_done_i(ev[2]), .test_done_i(ev[3]), .fault_i(ev[4]), .function_fault_code_i(code),
    .log_raddr_i(raddr), .test_option_parameter_o(opt), .stop_at_end_option_o(eot_o),
    .running_o(run), .end_stop_o(ends), .access_req_o(req), .seek_count_o(scnt),
    .fault_count_o(fcnt), .log_rdata_o(rdata));
  task automatic pulse(input logic [4:0] e);
    i_op.edges(1);
    ev = e;
    i_op.edges(1);
    ev = 5'h00;
  endtask
  task automatic set_opt(input logic [7:0] v);
    i_op.enter(1'b1, 8'h80);
    i_op.enter(1'b0, v);
    i_op.enter(1'b0, 8'h5A);
    i_op.edges(4);
  endtask
  // Clear, reload, initiate
  task automatic start;
    i_op.press(1);
    i_op.press(2);
    i_op.press(0);
  endtask
  task automatic log_chk(input logic [7:0] a, input logic [7:0] e);
    raddr = a;
    i_op.edges(2);
    `CHK("log data", e, rdata)
  endtask
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Run needs about 41000 cycles
  initial begin
    #400000;
    err_count++;
    give_verdict;
  end
  initial begin
    clk_i = 1'b0;
    rst_n_i = 1'b0;
    mode = 1'b0;
    kind = 3'h0;
    test = 8'h01;
    code = 8'h00;
    raddr = 8'hD0;
    ev = 5'h00;
    i_op.edges(2);
    rst_n_i = 1'b1;
    i_op.enter(1'b0, 8'h12);
    i_op.enter(1'b1, 8'h90);
    i_op.enter(1'b0, 8'h12);
    i_op.enter(1'b0, 8'h34);
    i_op.edges(4);
    `CHK("option", 16'h0000, opt)
    set_opt(8'hFF);
    `CHK("option", 16'h00FF, opt)
    i_op.enter(1'b1, 8'h81);
    i_op.enter(1'b0, 8'h00);
    i_op.enter(1'b0, 8'h00);
    i_op.edges(4);
    `CHK("option", 16'h00FF, opt)
    `CHK("stop option", 1'b1, eot_o)
    $display("Test entry done");
    set_opt(8'h01);
    mode = 1'b1;
    for (m = 0; m < 6; m++) begin
      kind = m[2:0];
      start;
      `CHK("running", 1'b1, run)
      if (m < 2) begin
        repeat (9999) pulse(5'h01);
        `CHK("early stop", 1'b0, ends)
      end
      pulse(m < 2 ? 5'h01 : (m == 5 ? 5'h04 : 5'h02));
      i_op.edges(2);
      `CHK("end stop", 1'b1, ends)
      if (m < 2) `CHK("seeks", 16'd10000, scnt)
      i_op.press(0);
      `CHK("restart", 1'b0, run)
    end
    $display("Test seek ends done");
    mode = 1'b0;
    start;
    pulse(5'h08);
    i_op.edges(2);
    `CHK("end stop", 1'b1, ends)
    set_opt(8'h00);
    for (m = 2; m < 6; m += 3) begin
      test = m[7:0];
      start;
      pulse(5'h08);
      i_op.edges(2);
      `CHK("end stop", 1'b1, ends)
    end
    test = 8'h01;
    kind = 3'h2;
    for (m = 0; m < 2; m++) begin
      mode = m[0];
      start;
      pulse(m != 0 ? 5'h02 : 5'h08);
      i_op.edges(2);
      `CHK("end stop", 1'b0, ends)
      `CHK("running", 1'b1, run)
      i_op.press(0);
      `CHK("running", 1'b0, run)
    end
    $display("Test loops done");
    set_opt(8'h02);
    mode = 1'b1;
    m = nreq;
    start;
    i_op.edges(10);
    `CHK("accesses", 1, nreq - m)
    i_op.press(0);
    i_op.edges(10);
    `CHK("accesses", 2, nreq - m)
    $display("Test single step done");
    set_opt(8'h04);
    code = 8'h3C;
    pulse(5'h10);
    set_opt(8'h00);
    code = 8'hC3;
    pulse(5'h10);
    i_op.edges(2);
    `CHK("fault count", 8'h01, fcnt)
    log_chk(8'hD0, 8'h3C);
    log_chk(8'hD1, 8'hC3);
    log_chk(8'hB0, 8'h3C);
    $display("Test fault log done");
    give_verdict;
  end
endmodule // tb_top
bind dtoc_test_control dtoc_chk u_chk (.*);
